// File: bench/tcc_rx_line.sv
`timescale 1ns/1ps
// serial receive line seen by the channel: idles high like a pulled-up line, then sends
// nBits alternating bits of bitLen cycles each, starting low
module tcc_rx_line (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic go,
  input wire logic [15:0] bitLen,
  input wire logic [7:0] nBits,
  output logic rxLine,
  output logic busy
);
  logic [15:0] cnt_ff;
  logic [7:0] bits_ff;
  // one counter per bit; the line is never left floating between frames
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rxLine <= 1'b1;
      busy <= 1'b0;
      cnt_ff <= 16'h0000;
      bits_ff <= 8'h00;
    end else if (go && !busy) begin
      rxLine <= 1'b0;
      busy <= 1'b1;
      cnt_ff <= bitLen - 16'h0001;
      bits_ff <= nBits - 8'h01;
    end else if (busy) begin
      if (cnt_ff != 16'h0000) begin
        cnt_ff <= cnt_ff - 16'h0001;
      end else if (bits_ff != 8'h00) begin
        rxLine <= ~rxLine;
        cnt_ff <= bitLen - 16'h0001;
        bits_ff <= bits_ff - 8'h01;
      end else begin
        rxLine <= 1'b1; // back to idle level
        busy <= 1'b0;
      end
    end
  end
endmodule

// File: bench/test_tcc_channel.sv
`timescale 1ns/1ps
module test_tcc_channel
  import tcc_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] divCnt = 3'h0;
  logic rxLine;
  logic outPin;
  logic eventIrq;
  logic go = 1'b0;
  logic mstIrq = 1'b0;
  logic busy;
  logic [15:0] bitLen = 16'h0014;
  int errors = 0;
  int cmpCount = 0;
  int cycles = 0;
  logic [31:0] r;
  logic e;

  // clock A every second cycle, clock B every eighth, so the two selections differ by four
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) divCnt <= divCnt + 3'h1;

  tcc_channel uut (.sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .prescaledClockA(divCnt[0]), .prescaledClockB(divCnt == 3'h7), .ch1TimerInput(rxLine),
    .masterIrq(mstIrq), .ch1OutPin(outPin), .chEventIrq(eventIrq));
  tcc_rx_line rxModel (.sys_clk(sys_clk), .rst(rst), .go(go), .bitLen(bitLen), .nBits(8'h08),
    .rxLine(rxLine), .busy(busy));

  task test_done;
    $display("errors %0d comparisons %0d", errors, cmpCount);
    if (errors == 0 && cmpCount > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // a hang counts as a mismatch and still ends in the normal report
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      test_done;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task chkRange(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    cmpCount++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask

  // one apb transfer; the request holds until pready is seen high at an edge
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdChk(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk(r, exp);
  endtask

  task waitIrq;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (eventIrq !== 1'b1 && n < 3000);
    chk({31'h0, eventIrq}, 32'h1);
  endtask

  task t_reset;
    for (int a = 0; a < 32; a += 4) rdChk(a[7:0], 32'h0);
    apb(8'h20, 1'b0, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
  endtask

  // every trigger and mode code against the prohibited flag; unused bits read 0
  task t_decode;
    logic bad;
    apb(ADDR_MODE_UPPER, 1'b1, 32'hFF);
    rdChk(ADDR_MODE_UPPER, 32'h9F);
    apb(ADDR_MODE_LOWER, 1'b1, 32'hFF);
    rdChk(ADDR_MODE_LOWER, 32'hCF);
    apb(ADDR_MODE_LOWER, 1'b1, 32'h04);
    for (int t = 0; t < 8; t++) begin
      bad = !(t == 0 || t == 1 || t == 2 || t == 4);
      apb(ADDR_MODE_UPPER, 1'b1, t);
      apb(ADDR_STATUS, 1'b0, 32'h0);
      chk({31'h0, r[STAT_BAD_BIT]}, {31'h0, bad});
    end
    apb(ADDR_MODE_UPPER, 1'b1, 32'h0);
    for (int m = 0; m < 16; m++) begin
      bad = !(m / 2 == 0 || m / 2 == 2 || m == 6 || m / 2 == 4 || m == 12);
      apb(ADDR_MODE_LOWER, 1'b1, m);
      apb(ADDR_STATUS, 1'b0, 32'h0);
      chk({31'h0, r[STAT_BAD_BIT]}, {31'h0, bad});
    end
  endtask

  task t_output;
    logic p;
    apb(ADDR_OUT_LEVEL, 1'b1, 32'h2);
    @(negedge sys_clk);
    chk({31'h0, outPin}, 32'h1);
    rdChk(ADDR_OUT_LEVEL, 32'h2);
    apb(ADDR_OUT_LEVEL, 1'b1, 32'h0);
    apb(ADDR_DATA, 1'b1, 32'h3);
    apb(ADDR_MODE_LOWER, 1'b1, 32'h0);
    apb(ADDR_CTRL, 1'b1, 32'h1);
    repeat (40) @(posedge sys_clk);
    chk({31'h0, outPin}, 32'h0);
    apb(ADDR_OUT_ENABLE, 1'b1, 32'h2);
    for (int n = 0; n < 100 && outPin !== 1'b1; n++) @(posedge sys_clk);
    chk({31'h0, outPin}, 32'h1);
    apb(ADDR_CTRL, 1'b1, 32'h2);
    // a toggle can still land on the stop edge, so take the level once it has settled
    @(negedge sys_clk);
    p = outPin;
    apb(ADDR_OUT_LEVEL, 1'b1, {30'h0, ~p, 1'b0});
    @(negedge sys_clk);
    chk({31'h0, outPin}, {31'h0, p});
    apb(ADDR_OUT_ENABLE, 1'b1, 32'h0);
    apb(ADDR_OUT_LEVEL, 1'b1, {30'h0, ~p, 1'b0});
    @(negedge sys_clk);
    chk({31'h0, outPin}, {31'h0, ~p});
  endtask

  // capture flag is sticky until software writes a one to it; channel must be stopped here
  task flagChk;
    rdChk(ADDR_STATUS, 32'h2);
    apb(ADDR_STATUS, 1'b1, 32'h2);
    rdChk(ADDR_STATUS, 32'h0);
  endtask

  // measure one interval of the partner's bit pattern; the second capture is a whole interval
  task capCase(input logic [7:0] up, input logic [7:0] lo, input logic [15:0] bl,
               input logic [31:0] mn, input logic [31:0] mx);
    apb(ADDR_MODE_UPPER, 1'b1, {24'h0, up});
    apb(ADDR_MODE_LOWER, 1'b1, {24'h0, lo});
    apb(ADDR_CTRL, 1'b1, 32'h1);
    bitLen <= bl;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    waitIrq;
    waitIrq;
    apb(ADDR_DATA, 1'b0, 32'h0);
    chkRange(r, mn, mx);
    apb(ADDR_CTRL, 1'b1, 32'h2);
    flagChk;
    while (busy) @(posedge sys_clk);
  endtask

  // master interrupt pulses 38 cycles apart act as capture triggers, clock A ticks every other cycle
  task t_master;
    apb(ADDR_MODE_UPPER, 1'b1, 32'h04);
    apb(ADDR_MODE_LOWER, 1'b1, 32'h04);
    apb(ADDR_CTRL, 1'b1, 32'h1);
    repeat (2) begin
      mstIrq <= 1'b1;
      @(posedge sys_clk);
      mstIrq <= 1'b0;
      waitIrq;
      repeat (36) @(posedge sys_clk);
    end
    apb(ADDR_DATA, 1'b0, 32'h0);
    chkRange(r, 32'd18, 32'd19);
    apb(ADDR_CTRL, 1'b1, 32'h2);
    flagChk;
  endtask

  // event counting on falling input edges, then a one-count run started by the input edge
  task t_modes;
    bitLen <= 16'd20;
    apb(ADDR_DATA, 1'b1, 32'h3);
    apb(ADDR_MODE_UPPER, 1'b1, 32'h10);
    apb(ADDR_MODE_LOWER, 1'b1, 32'h06);
    apb(ADDR_CTRL, 1'b1, 32'h1);
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    waitIrq;
    rdChk(ADDR_COUNT, 32'h3);
    apb(ADDR_CTRL, 1'b1, 32'h2);
    while (busy) @(posedge sys_clk);
    apb(ADDR_DATA, 1'b1, 32'h5);
    apb(ADDR_MODE_UPPER, 1'b1, 32'h01);
    apb(ADDR_MODE_LOWER, 1'b1, 32'h08);
    apb(ADDR_CTRL, 1'b1, 32'h1);
    rdChk(ADDR_STATUS, 32'h9);
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    waitIrq;
    rdChk(ADDR_STATUS, 32'h9);
    rdChk(ADDR_COUNT, 32'h0);
    apb(ADDR_CTRL, 1'b1, 32'h2);
    while (busy) @(posedge sys_clk);
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset;
    t_decode;
    t_output;
    capCase(8'h01, 8'h04, 16'd20, 32'd19, 32'd20);
    capCase(8'h81, 8'h04, 16'd32, 32'd7, 32'd8);
    capCase(8'h01, 8'h45, 16'd20, 32'd19, 32'd20);
    capCase(8'h02, 8'h04, 16'd20, 32'd9, 32'd10);
    capCase(8'h01, 8'h8C, 16'd20, 32'd9, 32'd10);
    capCase(8'h01, 8'hCC, 16'd20, 32'd9, 32'd10);
    capCase(8'h09, 8'h04, 16'd400, 32'd143, 32'd144);
    t_master;
    t_modes;
    test_done;
  end
endmodule

// File: include/tcc_pkg.sv
// Behaviour
// - The operation clock select bit picks prescaled clock A when 0 and prescaled clock B when 1.
// - The count clock select bit advances the counter on the operation clock when 0, on valid input edges when 1.
// - The width split bit runs the channel as one 16-bit timer when 0 and as an 8-bit timer when 1.
// - Trigger field: 000 software only, 001 valid edge, 010 both edges, 100 master interrupt, rest prohibited.
// - Edge field: 00 falling, 01 rising, 10 start falling/capture rising, 11 start rising/capture falling.
// - Mode field: 000x interval down, 010x capture up, 0110 event down, 100x one-count down, 1100 capture+one-count up.
// - The channel output level bit holds the timer output value, low for 0 and high for 1.
// - With output enable clear, counting leaves the pin alone and software writes to the level bit drive the pin.
// - With output enable set, writes to the level bit are ignored and the count operation sets and resets the pin; only interval and one-count modes toggle it.
package tcc_pkg;
  // apb byte addresses, one word each
  localparam logic [7:0] ADDR_MODE_UPPER = 8'h00;
  localparam logic [7:0] ADDR_MODE_LOWER = 8'h04;
  localparam logic [7:0] ADDR_OUT_LEVEL = 8'h08;
  localparam logic [7:0] ADDR_OUT_ENABLE = 8'h0C;
  localparam logic [7:0] ADDR_CTRL = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_DATA = 8'h18;
  localparam logic [7:0] ADDR_COUNT = 8'h1C;
  // field positions
  localparam int OP_CLK_BIT = 7;
  localparam int CNT_CLK_BIT = 4;
  localparam int SPLIT_BIT = 3;
  localparam int TRIG_LSB = 0;
  localparam int EDGE_LSB = 6;
  localparam int MODE_LSB = 0;
  localparam int CH1_BIT = 1;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_CAP_BIT = 1;
  localparam int STAT_BAD_BIT = 2;
  localparam int STAT_WAIT_BIT = 3;
  // writable bits and reset values
  localparam logic [7:0] MODE_UPPER_MASK = 8'h9F;
  localparam logic [7:0] MODE_LOWER_MASK = 8'hCF;
  localparam logic [7:0] MODE_UPPER_RST = 8'h00;
  localparam logic [7:0] MODE_LOWER_RST = 8'h00;
  localparam logic OUT_LEVEL_RST = 1'b0;
  localparam logic OUT_ENABLE_RST = 1'b0;
  localparam int CNT_WIDTH = 16;
  localparam logic [15:0] MASK8 = 16'h00FF;
  // trigger and edge codes
  localparam logic [2:0] TRIG_SW = 3'h0;
  localparam logic [2:0] TRIG_EDGE = 3'h1;
  localparam logic [2:0] TRIG_BOTH = 3'h2;
  localparam logic [2:0] TRIG_MASTER = 3'h4;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_LOW = 2'h2;
  localparam logic [1:0] EDGE_HIGH = 2'h3;

  typedef enum logic [5:0] {
    K_INTERVAL = 6'h01,
    K_CAPTURE = 6'h02,
    K_EVENT = 6'h04,
    K_ONE = 6'h08,
    K_CAPONE = 6'h10,
    K_BAD = 6'h20
  } tcc_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WAIT = 3'h2,
    ST_COUNT = 3'h4
  } tcc_state_t;

  // mode field decode; low bit is don't-care in three modes
  function automatic tcc_kind_t tcc_mode_kind(input logic [3:0] m);
    unique casez (m)
      4'b000?: tcc_mode_kind = K_INTERVAL;
      4'b010?: tcc_mode_kind = K_CAPTURE;
      4'b0110: tcc_mode_kind = K_EVENT;
      4'b100?: tcc_mode_kind = K_ONE;
      4'b1100: tcc_mode_kind = K_CAPONE;
      default: tcc_mode_kind = K_BAD;
    endcase
  endfunction

  function automatic logic tcc_trig_ok(input logic [2:0] t);
    tcc_trig_ok = (t == TRIG_SW) || (t == TRIG_EDGE) || (t == TRIG_BOTH) || (t == TRIG_MASTER);
  endfunction
endpackage

// File: include/tcc_trig_if.sv
`timescale 1ns/1ps
interface tcc_trig_if;
  logic timerIn;
  logic masterIrq;
  logic [1:0] edgeSel;
  logic [2:0] trigSel;
  logic validEdge;
  logic startTrig;
  logic captureTrig;
  modport gen (input timerIn, masterIrq, edgeSel, trigSel, output validEdge, startTrig, captureTrig);
  modport use_side (output timerIn, masterIrq, edgeSel, trigSel, input validEdge, startTrig, captureTrig);
endinterface

// File: verilog/tcc_channel.sv
`timescale 1ns/1ps
module tcc_channel
  import tcc_pkg::*;
#(
  parameter int CNT_W = CNT_WIDTH
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic prescaledClockA,
  input wire logic prescaledClockB,
  input wire logic ch1TimerInput,
  input wire logic masterIrq,
  output logic ch1OutPin,
  output logic chEventIrq
);
  tcc_trig_if trg ();

  logic [7:0] modeUpper_ff;
  logic [7:0] modeLower_ff;
  logic level_ff;
  logic outEnable_ff;
  logic capFlag_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] data_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic irq_ff;
  tcc_state_t state_ff;
  tcc_state_t nxt_state;
  logic [CNT_W-1:0] nxt_cnt;
  logic capLoad;
  logic evt;
  logic outToggle;

  tcc_trig_gen u_trig (
    .sys_clk(sys_clk),
    .rst(rst),
    .trg(trg)
  );

  // configuration fields
  logic opClkSel;
  logic cntClkSel;
  logic split;
  tcc_kind_t kind;
  logic cfgOk;
  assign opClkSel = modeUpper_ff[OP_CLK_BIT];
  assign cntClkSel = modeUpper_ff[CNT_CLK_BIT];
  assign split = modeUpper_ff[SPLIT_BIT];
  assign kind = tcc_mode_kind(modeLower_ff[MODE_LSB +: 4]);
  assign cfgOk = (kind != K_BAD) && tcc_trig_ok(modeUpper_ff[TRIG_LSB +: 3]);
  assign trg.timerIn = ch1TimerInput;
  assign trg.masterIrq = masterIrq;
  assign trg.edgeSel = modeLower_ff[EDGE_LSB +: 2];
  assign trg.trigSel = modeUpper_ff[TRIG_LSB +: 3];

  // count clock: prescaled enable pulse or a valid input edge
  logic opTick;
  logic tick;
  assign opTick = opClkSel ? prescaledClockB : prescaledClockA;
  assign tick = cntClkSel ? trg.validEdge : opTick;

  // 8-bit split simply masks the upper byte; the upper half is not a second timer here
  logic [CNT_W-1:0] cntMask;
  logic [CNT_W-1:0] cntInc;
  logic [CNT_W-1:0] cntDec;
  logic [CNT_W-1:0] reload;
  logic cntZero;
  assign cntMask = split ? CNT_W'(MASK8) : '1;
  assign cntInc = (cnt_ff + CNT_W'(1)) & cntMask;
  assign cntDec = (cnt_ff - CNT_W'(1)) & cntMask;
  assign reload = data_ff & cntMask;
  assign cntZero = (cnt_ff & cntMask) == '0;

  // apb decode; no wait state, read data is registered during setup so it comes from a flop
  logic setup;
  logic access;
  logic wrEn;
  logic selUpper;
  logic selLower;
  logic selLevel;
  logic selEnable;
  logic selCtrl;
  logic selStatus;
  logic selData;
  logic selCount;
  logic addrHit;
  assign setup = psel & ~penable;
  assign access = psel & penable & pready_ff;
  assign wrEn = access & pwrite;
  assign selUpper = paddr == ADDR_MODE_UPPER;
  assign selLower = paddr == ADDR_MODE_LOWER;
  assign selLevel = paddr == ADDR_OUT_LEVEL;
  assign selEnable = paddr == ADDR_OUT_ENABLE;
  assign selCtrl = paddr == ADDR_CTRL;
  assign selStatus = paddr == ADDR_STATUS;
  assign selData = paddr == ADDR_DATA;
  assign selCount = paddr == ADDR_COUNT;
  assign addrHit = selUpper | selLower | selLevel | selEnable | selCtrl | selStatus | selData | selCount;

  logic wrLevel;
  logic swStart;
  logic swStop;
  logic capClr;
  assign wrLevel = wrEn & selLevel;
  assign swStart = wrEn & selCtrl & pwdata[CTRL_START_BIT];
  assign swStop = wrEn & selCtrl & pwdata[CTRL_STOP_BIT];
  assign capClr = wrEn & selStatus & pwdata[STAT_CAP_BIT];

  // read mux; unmapped and reserved bits read zero
  logic [7:0] statusVal;
  logic [31:0] rdMux;
  assign statusVal = {4'h0, state_ff == ST_WAIT, ~cfgOk, capFlag_ff, state_ff != ST_IDLE};
  assign rdMux = selUpper ? {24'h0, modeUpper_ff} :
                 selLower ? {24'h0, modeLower_ff} :
                 selLevel ? 32'(level_ff) << CH1_BIT :
                 selEnable ? 32'(outEnable_ff) << CH1_BIT :
                 selStatus ? {24'h0, statusVal} :
                 selData ? 32'(data_ff) :
                 selCount ? 32'(cnt_ff) : 32'h0000_0000;

  // bus answer flops
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup & ~addrHit;
      prdata_ff <= setup ? rdMux : prdata_ff;
    end
  end

  // mode registers; a prohibited code is stored but keeps the channel idle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      modeUpper_ff <= MODE_UPPER_RST;
      modeLower_ff <= MODE_LOWER_RST;
      outEnable_ff <= OUT_ENABLE_RST;
    end else begin
      if (wrEn && selUpper) modeUpper_ff <= pwdata[7:0] & MODE_UPPER_MASK;
      if (wrEn && selLower) modeLower_ff <= pwdata[7:0] & MODE_LOWER_MASK;
      if (wrEn && selEnable) outEnable_ff <= pwdata[CH1_BIT];
    end
  end

  // output level: software owns it when disabled, the count operation when enabled
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      level_ff <= OUT_LEVEL_RST;
    end else if (outEnable_ff) begin
      if (outToggle) level_ff <= ~level_ff;
    end else if (wrLevel) begin
      level_ff <= pwdata[CH1_BIT];
    end
  end

  // counting sequence
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    capLoad = 1'b0;
    evt = 1'b0;
    outToggle = 1'b0;
    unique case (state_ff)
      ST_IDLE: begin
        if (swStart && cfgOk) begin
          if (kind == K_ONE || kind == K_CAPONE) begin
            nxt_state = ST_WAIT;
          end else begin
            nxt_state = ST_COUNT;
            nxt_cnt = (kind == K_CAPTURE) ? '0 : reload;
          end
        end
      end
      ST_WAIT: begin
        if (trg.startTrig || swStart) begin
          nxt_state = ST_COUNT;
          nxt_cnt = (kind == K_CAPONE) ? '0 : reload;
        end
      end
      ST_COUNT: begin
        unique case (kind)
          K_INTERVAL, K_EVENT: begin
            if (tick && cntZero) begin
              nxt_cnt = reload;
              evt = 1'b1;
              outToggle = kind == K_INTERVAL;
            end else if (tick) begin
              nxt_cnt = cntDec;
            end
          end
          K_ONE: begin
            if (tick && cntZero) begin
              evt = 1'b1;
              outToggle = 1'b1;
              nxt_state = ST_WAIT;
            end else if (tick) begin
              nxt_cnt = cntDec;
            end
          end
          K_CAPTURE: begin
            if (trg.captureTrig) begin
              capLoad = 1'b1;
              evt = 1'b1;
              nxt_cnt = '0;
            end else if (tick) begin
              nxt_cnt = cntInc;
            end
          end
          K_CAPONE: begin
            if (trg.captureTrig) begin
              capLoad = 1'b1;
              evt = 1'b1;
              nxt_state = ST_WAIT;
            end else if (tick) begin
              nxt_cnt = cntInc;
            end
          end
          K_BAD: begin
            nxt_state = ST_IDLE;
          end
        endcase
      end
    endcase
    if (swStop || !cfgOk) begin
      nxt_state = ST_IDLE;
    end
  end

  // counter, data and state; capture beats a software data write
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      cnt_ff <= '0;
      data_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt & cntMask;
      irq_ff <= evt;
      if (capLoad) begin
        data_ff <= cnt_ff;
      end else if (wrEn && selData) begin
        data_ff <= pwdata[CNT_W-1:0];
      end
    end
  end

  // sticky capture flag, a new capture wins over the clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      capFlag_ff <= 1'b0;
    end else begin
      capFlag_ff <= capLoad | (capFlag_ff & ~capClr);
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign ch1OutPin = level_ff;
  assign chEventIrq = irq_ff;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence seqLevelWrite;
    wrLevel && !outEnable_ff;
  endsequence

  sequence seqPinFollows;
    ch1OutPin == $past(pwdata[CH1_BIT]);
  endsequence

  AST_OPCLK_B: assert property (
    (state_ff == ST_COUNT && kind == K_INTERVAL && !cntClkSel && opClkSel && !prescaledClockB && !swStop)
      |=> $stable(cnt_ff)
  ) else $error("counter moved without a tick of prescaled clock B");

  AST_EDGE_COUNT: assert property (
    (state_ff == ST_COUNT && kind == K_INTERVAL && cntClkSel && trg.validEdge && !cntZero && !swStop && cfgOk)
      |=> cnt_ff == $past(cntDec)
  ) else $error("valid input edge did not decrement the counter");

  AST_SPLIT_MASK: assert property (
    split |=> (cnt_ff & ~CNT_W'(MASK8)) == '0
  ) else $error("upper byte nonzero in 8-bit operation");

  AST_CAPTURE_UP: assert property (
    (state_ff == ST_COUNT && kind == K_CAPTURE && tick && !trg.captureTrig && !swStop && cfgOk)
      |=> cnt_ff == $past(cntInc)
  ) else $error("capture mode did not count up");

  AST_SW_LEVEL: assert property (
    seqLevelWrite |=> seqPinFollows
  ) else $error("pin does not follow software level write");

  AST_WRITE_IGNORED: assert property (
    (outEnable_ff && wrLevel && !outToggle) |=> $stable(ch1OutPin)
  ) else $error("level write not ignored while output enabled");

  AST_CAPTURE_LATCH: assert property (
    capLoad |=> (data_ff == $past(cnt_ff) && chEventIrq && capFlag_ff) ##1 !chEventIrq || $past(capLoad)
  ) else $error("capture did not latch count and raise the interrupt");

  AST_BAD_IDLE: assert property (
    !cfgOk |=> state_ff == ST_IDLE
  ) else $error("prohibited code left the channel running");

  AST_COUNT_NO_PIN: assert property (
    (!outEnable_ff && !wrLevel) |=> $stable(ch1OutPin)
  ) else $error("pin moved while output enable was clear");

  AST_TOGGLE_ON_COUNT: assert property (
    (outEnable_ff && outToggle) |=> ch1OutPin != $past(ch1OutPin)
  ) else $error("enabled output did not follow the count operation");

  AST_RELOAD_AT_ZERO: assert property (
    (state_ff == ST_COUNT && kind == K_EVENT && tick && cntZero && !swStop) |=> cnt_ff == $past(reload)
  ) else $error("event counter did not reload at zero");

  sequence seqOneCountEnd;
    state_ff == ST_COUNT && kind == K_ONE && tick && cntZero && cfgOk && !swStop;
  endsequence

  AST_ONE_COUNT_WAIT: assert property (
    seqOneCountEnd |=> (state_ff == ST_WAIT && chEventIrq) ##1 !chEventIrq
  ) else $error("one-count run did not stop and wait for the next start");
endmodule

// File: verilog/tcc_trig_gen.sv
`timescale 1ns/1ps
module tcc_trig_gen
  import tcc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  tcc_trig_if.gen trg
);
  logic prev_ff;
  logic rise;
  logic fall;
  logic anyEdge;
  logic startEdge;
  logic capEdge;

  // previous input level, the input is already synchronous
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prev_ff <= 1'b1; // idle level of a pulled-up receive line, so release gives no false edge
    end else begin
      prev_ff <= trg.timerIn;
    end
  end

  // edge selection
  assign rise = ~prev_ff & trg.timerIn;
  assign fall = prev_ff & ~trg.timerIn;
  assign anyEdge = rise | fall;
  assign trg.validEdge = (trg.edgeSel == EDGE_FALL) ? fall : (trg.edgeSel == EDGE_RISE) ? rise : anyEdge;
  assign startEdge = (trg.edgeSel == EDGE_LOW) ? fall : (trg.edgeSel == EDGE_HIGH) ? rise : trg.validEdge;
  assign capEdge = (trg.edgeSel == EDGE_LOW) ? rise : (trg.edgeSel == EDGE_HIGH) ? fall : trg.validEdge;

  // trigger source; prohibited codes give no trigger at all
  assign trg.startTrig = (trg.trigSel == TRIG_EDGE) ? startEdge : (trg.trigSel == TRIG_BOTH) ? anyEdge :
                         (trg.trigSel == TRIG_MASTER) ? trg.masterIrq : 1'b0;
  assign trg.captureTrig = (trg.trigSel == TRIG_EDGE) ? capEdge : (trg.trigSel == TRIG_BOTH) ? anyEdge :
                           (trg.trigSel == TRIG_MASTER) ? trg.masterIrq : 1'b0;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_TRIG_SOURCE: assert property (
    (trg.trigSel == TRIG_SW) |-> (!trg.startTrig && !trg.captureTrig)
  ) else $error("software-only trigger produced a hardware trigger");

  AST_LOW_WIDTH_EDGES: assert property (
    (trg.trigSel == TRIG_EDGE && trg.edgeSel == EDGE_LOW && prev_ff && !trg.timerIn)
      |-> (trg.startTrig && !trg.captureTrig)
  ) else $error("low-width falling edge must start and not capture");
endmodule
